// [core/oledhp_host.sv]
// Purpose: Host controller driving an OLED module over its 8080-style parallel pins.
// Assumes: Module straps tied high for 8080 mode; the module runs no clock of its own.
// Notes: Resets the module, sends the init sequence, then serves user writes and reads.
// Summary of operation
// - Host uses 8080 protocol; both bus-select straps driven high.
// - Command write: select low, chip select and byte together, then write low, then release in order.
// - After reset delay, init starts with display off and ends with display on.
// - Init sends segment remap and reversed common-line scan as single commands.
// - Init sends common-pin configuration followed by its parameter byte.
`timescale 1ns/100ps
`include "oled_defs.svh"
module oledhp_host
  import oledhp_pkg::*;
#(
  parameter int RESET_LOW_CYC = `OLED_RESET_LOW_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic req_is_data,
  input wire logic [7:0] req_byte,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic init_done,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] data_in,
  output logic chip_sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic dc_sel,
  output logic reset_in_n,
  output logic bus_sel_strap_a,
  output logic bus_sel_strap_b
);
  // The read strobe covers the access time plus the pin edge, three synchroniser stages
  // and the agreement stage, so the byte taken has settled on the bus.
  localparam int WR_STB = `OLED_WR_LOW_CYC;
  localparam int RD_STB_ACC = `OLED_ACC_CYC + `OLED_SETTLE_CYC;
  localparam int RD_STB = (RD_STB_ACC > `OLED_RD_LOW_CYC) ? RD_STB_ACC : `OLED_RD_LOW_CYC;
  // The gap also stretches each transfer to the least cycle time from strobe to strobe.
  localparam int WR_GAP_CYC = `OLED_CYCLE_CYC - WR_STB - 2;
  localparam int RD_GAP_CYC = `OLED_CYCLE_CYC - RD_STB - 2;
  localparam int WR_GAP = (WR_GAP_CYC > `OLED_WR_HIGH_CYC) ? WR_GAP_CYC : `OLED_WR_HIGH_CYC;
  localparam int RD_GAP = (RD_GAP_CYC > `OLED_RD_HIGH_CYC) ? RD_GAP_CYC : `OLED_RD_HIGH_CYC;
  localparam logic [4:0] WR_LAST = 5'(WR_STB - 1);
  localparam logic [4:0] RD_LAST = 5'(RD_STB - 1);
  localparam logic [4:0] WR_GAP_LAST = 5'(WR_GAP - 1);
  localparam logic [4:0] RD_GAP_LAST = 5'(RD_GAP - 1);
  localparam logic [4:0] INIT_LAST = 5'(`OLED_INIT_LEN - 1);

  oledhp_state_t state_r, state_nxt;
  logic [31:0] rst_cnt_r;
  logic [4:0] cnt_r, cnt_nxt;
  logic [4:0] idx_r;
  logic is_read_r, is_init_r;
  logic [7:0] din_s1_r, din_s2_r, din_s3_r, din_stable_r;
  logic [7:0] init_byte;
  logic cs_nxt, rd_nxt, wr_nxt, dc_nxt, oe_nxt;
  logic is_read_nxt, dc_sel_nxt;
  logic [7:0] byte_nxt;
  wire starting;
  wire [4:0] init_idx = (state_r == OLEDHP_GAP) ? 5'(idx_r + 5'd1) : idx_r;

  // Command and parameter bytes in the order the module expects them.
  always_comb begin
    case (init_idx)
      5'd0: init_byte = `OLED_CMD_DISP_OFF;
      5'd1: init_byte = `OLED_CMD_CONTRAST;
      5'd2: init_byte = `OLED_PAR_CONTRAST;
      5'd3: init_byte = `OLED_CMD_MUX;
      5'd4: init_byte = `OLED_PAR_MUX;
      5'd5: init_byte = `OLED_CMD_SEG_REMAP;
      5'd6: init_byte = `OLED_CMD_OFFSET;
      5'd7: init_byte = `OLED_PAR_OFFSET;
      5'd8: init_byte = `OLED_CMD_START_LINE;
      5'd9: init_byte = `OLED_CMD_SCAN_REV;
      5'd10: init_byte = `OLED_CMD_COM_PINS;
      5'd11: init_byte = `OLED_PAR_COM_PINS;
      5'd12: init_byte = `OLED_CMD_PRECHARGE;
      5'd13: init_byte = `OLED_PAR_PRECHARGE;
      5'd14: init_byte = `OLED_CMD_VCOMH;
      5'd15: init_byte = `OLED_PAR_VCOMH;
      5'd16: init_byte = `OLED_CMD_NORMAL;
      5'd17: init_byte = `OLED_CMD_NO_INV;
      default: init_byte = `OLED_CMD_DISP_ON;
    endcase
  end

  wire strobe_len_done = is_read_r ? (cnt_r >= RD_LAST) : (cnt_r >= WR_LAST);
  wire gap_done = is_read_r ? (cnt_r >= RD_GAP_LAST) : (cnt_r >= WR_GAP_LAST);
  wire take_user = req_valid && init_done;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 5'd1;
    case (state_r)
      OLEDHP_RST_LOW: begin
        cnt_nxt = 5'd0;
        if (rst_cnt_r >= 32'(RESET_LOW_CYC)) state_nxt = OLEDHP_INIT;
      end
      OLEDHP_INIT: begin
        cnt_nxt = 5'd0;
        state_nxt = OLEDHP_SETUP;
      end
      OLEDHP_IDLE: begin
        cnt_nxt = 5'd0;
        if (take_user) state_nxt = OLEDHP_SETUP;
      end
      OLEDHP_SETUP: begin
        cnt_nxt = 5'd0;
        state_nxt = OLEDHP_STROBE;
      end
      OLEDHP_STROBE: begin
        if (strobe_len_done) begin
          state_nxt = OLEDHP_RELEASE;
          cnt_nxt = 5'd0;
        end
      end
      OLEDHP_RELEASE: begin
        cnt_nxt = 5'd0;
        state_nxt = OLEDHP_GAP;
      end
      default: begin
        if (gap_done) begin
          cnt_nxt = 5'd0;
          if (is_init_r && idx_r != INIT_LAST) state_nxt = OLEDHP_SETUP;
          else state_nxt = OLEDHP_IDLE;
        end
      end
    endcase
  end

  // Pin levels per state; strobe only moves with chip select low.
  assign cs_nxt = !(state_nxt == OLEDHP_SETUP || state_nxt == OLEDHP_STROBE ||
                    state_nxt == OLEDHP_RELEASE);
  assign wr_nxt = !(state_nxt == OLEDHP_STROBE && !is_read_nxt);
  assign rd_nxt = !(state_nxt == OLEDHP_STROBE && is_read_nxt);
  assign oe_nxt = !is_read_nxt && (state_nxt == OLEDHP_SETUP ||
                  state_nxt == OLEDHP_STROBE || state_nxt == OLEDHP_RELEASE);
  // Select returns high one cycle after chip select has risen.
  assign dc_nxt = (!starting && state_r == OLEDHP_GAP) ? 1'b1 : dc_sel_nxt;
  assign starting = (state_r == OLEDHP_INIT) || (state_r == OLEDHP_IDLE && take_user) ||
                    (state_r == OLEDHP_GAP && state_nxt == OLEDHP_SETUP);
  always_comb begin
    is_read_nxt = is_read_r;
    dc_sel_nxt = dc_sel;
    byte_nxt = data_out;
    if (state_r == OLEDHP_IDLE && take_user) begin
      is_read_nxt = req_read;
      dc_sel_nxt = req_is_data;
      byte_nxt = req_byte;
    end else if (starting) begin
      is_read_nxt = 1'b0;
      dc_sel_nxt = 1'b0;
      byte_nxt = init_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= OLEDHP_RST_LOW;
      rst_cnt_r <= 32'h0000_0000;
      cnt_r <= 5'h00;
      idx_r <= 5'h00;
      is_read_r <= 1'b0;
      is_init_r <= 1'b0;
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
      din_s3_r <= 8'h00;
      din_stable_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      rst_cnt_r <= (state_r == OLEDHP_RST_LOW) ? rst_cnt_r + 32'h1 : rst_cnt_r;
      cnt_r <= cnt_nxt;
      is_read_r <= is_read_nxt;
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
      din_s3_r <= din_s2_r;
      if (din_s2_r == din_s3_r) din_stable_r <= din_s3_r;
      if (state_r == OLEDHP_INIT) is_init_r <= 1'b1;
      else if (state_r == OLEDHP_GAP && state_nxt == OLEDHP_IDLE) is_init_r <= 1'b0;
      if (state_r == OLEDHP_GAP && is_init_r && state_nxt == OLEDHP_SETUP)
        idx_r <= idx_r + 5'd1;
    end
  end

  // Output pins and user side, all registered.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      chip_sel_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      dc_sel <= 1'b1;
      reset_in_n <= 1'b0;
      bus_sel_strap_a <= 1'b1;
      bus_sel_strap_b <= 1'b1;
      init_done <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_byte <= 8'h00;
    end else begin
      data_out <= byte_nxt;
      data_oe <= oe_nxt;
      chip_sel_n <= cs_nxt;
      rd_n <= rd_nxt;
      wr_n <= wr_nxt;
      dc_sel <= dc_nxt;
      reset_in_n <= (state_nxt != OLEDHP_RST_LOW);
      bus_sel_strap_a <= 1'b1;
      bus_sel_strap_b <= 1'b1;
      if (state_r == OLEDHP_GAP && is_init_r && state_nxt == OLEDHP_IDLE)
        init_done <= 1'b1;
      req_ready <= (state_nxt == OLEDHP_IDLE) && (init_done || is_init_r) &&
                   !(state_r == OLEDHP_IDLE && take_user);
      rsp_valid <= (state_r == OLEDHP_STROBE) && is_read_r && strobe_len_done;
      // Taken from the agreed stage; the read strobe outlasts access and that delay.
      if (state_r == OLEDHP_STROBE && is_read_r && strobe_len_done)
        rsp_byte <= din_stable_r;
    end
  end
endmodule : oledhp_host

// [core/oled_defs.svh]
// Purpose: Timing counts and init command bytes for the OLED parallel host port.
// Assumes: clk_sys runs at 100 MHz, a period of 10 ns.
// Notes: Least times round up to whole cycles.
`ifndef OLED_DEFS_SVH
`define OLED_DEFS_SVH
`define OLED_CLK_NS 10
`define OLED_WR_LOW_NS 60
`define OLED_WR_HIGH_NS 60
`define OLED_RD_LOW_NS 120
`define OLED_RD_HIGH_NS 60
`define OLED_ACC_NS 140
`define OLED_CYCLE_NS 300
`define OLED_WR_LOW_CYC ((`OLED_WR_LOW_NS + `OLED_CLK_NS - 1) / `OLED_CLK_NS)
`define OLED_WR_HIGH_CYC ((`OLED_WR_HIGH_NS + `OLED_CLK_NS - 1) / `OLED_CLK_NS)
`define OLED_RD_LOW_CYC ((`OLED_RD_LOW_NS + `OLED_CLK_NS - 1) / `OLED_CLK_NS)
`define OLED_RD_HIGH_CYC ((`OLED_RD_HIGH_NS + `OLED_CLK_NS - 1) / `OLED_CLK_NS)
`define OLED_ACC_CYC ((`OLED_ACC_NS + `OLED_CLK_NS - 1) / `OLED_CLK_NS)
`define OLED_CYCLE_CYC ((`OLED_CYCLE_NS + `OLED_CLK_NS - 1) / `OLED_CLK_NS)
`define OLED_SETTLE_CYC 5
`define OLED_RESET_LOW_DEF 100000
`define OLED_INIT_LEN 19
`define OLED_CMD_DISP_OFF 8'hae
`define OLED_CMD_CONTRAST 8'h81
`define OLED_PAR_CONTRAST 8'hff
`define OLED_CMD_MUX 8'ha8
`define OLED_PAR_MUX 8'h3f
`define OLED_CMD_SEG_REMAP 8'ha0
`define OLED_CMD_OFFSET 8'hd3
`define OLED_PAR_OFFSET 8'h00
`define OLED_CMD_START_LINE 8'h40
`define OLED_CMD_SCAN_REV 8'hc8
`define OLED_CMD_COM_PINS 8'hda
`define OLED_PAR_COM_PINS 8'h12
`define OLED_CMD_PRECHARGE 8'hd9
`define OLED_PAR_PRECHARGE 8'hf1
`define OLED_CMD_VCOMH 8'hdb
`define OLED_PAR_VCOMH 8'h49
`define OLED_CMD_NORMAL 8'ha4
`define OLED_CMD_NO_INV 8'ha6
`define OLED_CMD_DISP_ON 8'haf
`endif

// [core/oledhp_pkg.sv]
// Purpose: Types for the OLED parallel host port.
// Assumes: Nothing beyond the defs header.
// Notes: One-hot state codes.
package oledhp_pkg;
  typedef enum logic [6:0] {
    OLEDHP_RST_LOW = 7'h01,
    OLEDHP_INIT = 7'h02,
    OLEDHP_IDLE = 7'h04,
    OLEDHP_SETUP = 7'h08,
    OLEDHP_STROBE = 7'h10,
    OLEDHP_RELEASE = 7'h20,
    OLEDHP_GAP = 7'h40
  } oledhp_state_t;
endpackage : oledhp_pkg

// [test/oledhp_properties.sv]
// Purpose: Port checker for the OLED host port.
// Assumes: One clock domain, clk_sys; strobe widths as handed over.
// Notes: Bound to the host top module.
`timescale 1ns/100ps
module oledhp_props #(
  parameter int RESET_LOW_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic init_done,
  input wire logic data_oe,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic dc_sel,
  input wire logic reset_in_n,
  input wire logic bus_sel_strap_a,
  input wire logic bus_sel_strap_b
);
  int low_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) low_cnt <= 0;
    else if (!reset_in_n) low_cnt <= low_cnt + 1;
  end
  straps_high_a: assert property (bus_sel_strap_a && bus_sel_strap_b) else $error("strap low");
  strobe_sel_a: assert property (!wr_n || !rd_n |-> !chip_sel_n) else $error("strobe no cs");
  one_strobe_a: assert property (!(!wr_n && !rd_n)) else $error("both strobes");
  write_drive_a: assert property (!wr_n |-> data_oe) else $error("write undriven");
  read_float_a: assert property (!rd_n |-> !data_oe) else $error("read driven");
  wr_width_a: assert property ($fell(wr_n) |-> !wr_n [*6] ##1 wr_n) else $error("wr width");
  rd_width_a: assert property ($fell(rd_n) |-> !rd_n [*8] ##1 !rd_n [*8] ##1 !rd_n [*3] ##1 rd_n)
    else $error("rd width");
  dc_steady_a: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(dc_sel))
    else $error("dc moved");
  release_order_a: assert property ($rose(wr_n) && !dc_sel |-> !chip_sel_n ##1
    chip_sel_n && !dc_sel ##1 dc_sel) else $error("release order");
  reset_hold_a: assert property ($rose(reset_in_n) |-> low_cnt + 1 >= RESET_LOW_CYC)
    else $error("reset short");
  ready_init_a: assert property (req_ready |-> init_done) else $error("ready early");
endmodule : oledhp_props
bind oledhp_host oledhp_props #(.RESET_LOW_CYC(RESET_LOW_CYC)) u_props (.clk_sys(clk_sys),
  .rst_n(rst_n), .req_ready(req_ready), .init_done(init_done), .data_oe(data_oe),
  .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n), .dc_sel(dc_sel), .reset_in_n(reset_in_n),
  .bus_sel_strap_a(bus_sel_strap_a), .bus_sel_strap_b(bus_sel_strap_b));

// [test/oledhp_panel.sv]
// Purpose: Behavioural OLED module on the parallel pins.
// Assumes: 8080 mode; the module runs no clock of its own.
// Notes: A floating bus shows the inverse of the read byte, so stale data cannot pass.
`timescale 1ns/100ps
module oledhp_panel #(
  parameter logic [7:0] READ_BYTE = 8'h5a
) (
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic dc_sel,
  input wire logic reset_in_n,
  output logic [7:0] bus
);
  logic [7:0] cmd_q[$];
  logic [7:0] dat_q[$];
  logic [7:0] stray = 8'h00;
  assign bus = data_oe ? data_out : (!chip_sel_n && !rd_n) ? READ_BYTE : ~READ_BYTE;
  always @(posedge wr_n) begin
    if (reset_in_n !== 1'b1) stray = stray;
    else if (chip_sel_n) stray = stray + 8'h01;
    else if (dc_sel) dat_q.push_back(bus);
    else cmd_q.push_back(bus);
  end
endmodule : oledhp_panel

// [test/tb_oled_parallel_host_port.sv]
// Purpose: Self-checking bench for the OLED host port.
// Assumes: 100 MHz clk_sys; short module reset hold.
// Notes: Inputs change on the falling edge.
`timescale 1ns/100ps
`include "oled_defs.svh"
module tb_oled_parallel_host_port;
  localparam int RST_CYC = 20;
  localparam logic [7:0] EXP [19] = '{`OLED_CMD_DISP_OFF, `OLED_CMD_CONTRAST, `OLED_PAR_CONTRAST,
    `OLED_CMD_MUX, `OLED_PAR_MUX, `OLED_CMD_SEG_REMAP, `OLED_CMD_OFFSET, `OLED_PAR_OFFSET,
    `OLED_CMD_START_LINE, `OLED_CMD_SCAN_REV, `OLED_CMD_COM_PINS, `OLED_PAR_COM_PINS,
    `OLED_CMD_PRECHARGE, `OLED_PAR_PRECHARGE, `OLED_CMD_VCOMH, `OLED_PAR_VCOMH,
    `OLED_CMD_NORMAL, `OLED_CMD_NO_INV, `OLED_CMD_DISP_ON};
  logic clk_sys = 0, rst_n = 0, req_valid = 0, req_read = 0, req_is_data = 0;
  logic [7:0] req_byte = 8'h00;
  logic req_ready, rsp_valid, init_done, data_oe, chip_sel_n, rd_n, wr_n, dc_sel, reset_in_n;
  logic strap_a, strap_b;
  logic [7:0] rsp_byte, data_out, bus;
  int err_total = 0, checks_done = 0;
  always #5 clk_sys = ~clk_sys;
  oledhp_host #(.RESET_LOW_CYC(RST_CYC)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .req_valid(req_valid), .req_read(req_read), .req_is_data(req_is_data), .req_byte(req_byte),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .init_done(init_done),
    .data_out(data_out), .data_oe(data_oe), .data_in(bus), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
    .wr_n(wr_n), .dc_sel(dc_sel), .reset_in_n(reset_in_n), .bus_sel_strap_a(strap_a),
    .bus_sel_strap_b(strap_b));
  oledhp_panel panel (.data_out(data_out), .data_oe(data_oe), .chip_sel_n(chip_sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .dc_sel(dc_sel), .reset_in_n(reset_in_n), .bus(bus));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check8
  task automatic wait_high(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    if (sig !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
  endtask : wait_high
  task automatic do_req(input logic rd, input logic dat, input logic [7:0] b);
    @(negedge clk_sys);
    {req_valid, req_read, req_is_data, req_byte} = {1'b1, rd, dat, b};
    wait_high(req_ready);
    @(negedge clk_sys);
    req_valid = 0;
    if (rd) wait_high(rsp_valid);
    else wait_high(req_ready);
  endtask : do_req
  task automatic t_init();
    int n;
    n = 0;
    while (reset_in_n !== 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    check8("reset_hold", 8'h01, 8'(n >= RST_CYC));
    wait_high(init_done);
    check8("init_len", 8'd19, 8'(panel.cmd_q.size()));
    for (int i = 0; i < 19; i++) check8("init_byte", EXP[i], panel.cmd_q[i]);
    check8("init_data", 8'h00, 8'(panel.dat_q.size()));
  endtask : t_init
  task automatic t_traffic();
    do_req(1'b0, 1'b0, 8'h81);
    do_req(1'b0, 1'b0, 8'h7f);
    do_req(1'b0, 1'b1, 8'ha5);
    check8("cmd_tail", 8'h7f, panel.cmd_q[20]);
    check8("cmd_head", 8'h81, panel.cmd_q[19]);
    check8("dat_byte", 8'ha5, panel.dat_q[0]);
    do_req(1'b1, 1'b1, 8'h00);
    check8("rd_byte", 8'h5a, rsp_byte);
    check8("stray", 8'h00, panel.stray);
    check8("straps", 8'h03, {6'h00, strap_a, strap_b});
  endtask : t_traffic
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1;
    t_init();
    t_traffic();
    tally_and_finish();
  end
endmodule : tb_oled_parallel_host_port
